/* core/erc_ctrl.sv */
// control logic of an ecc dynamic ram expansion board
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`timescale 1ns/1ps
`include "erc_map.svh"
module erc_ctrl (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // board straps
  input wire logic [1:0] page_sel_i,
  input wire logic [7:0] base_block_i,
  input wire logic [3:0] port_sel_i,
  input wire logic [7:0] spare_port_i,
  // system bus memory side
  input wire logic [23:0] mem_addr_i,
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire logic byte_en_n_i,
  input wire logic [15:0] mem_wdata_i,
  output logic [15:0] mem_rdata_o,
  output logic mem_ack_o,
  // system bus io side
  input wire logic [7:0] io_addr_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  output logic io_ack_o,
  output logic int_o,
  // memory protect
  input wire logic mem_protect_n_i,
  // ram array
  output logic [18:0] ram_addr_o,
  output logic ram_rd_o,
  output logic [1:0] ram_wr_o,
  output logic [15:0] ram_wdata_o,
  input wire logic [15:0] ram_rdata_i,
  output logic check_wr_o,
  output logic [5:0] check_wdata_o,
  input wire logic [5:0] check_rdata_i,
  output logic refresh_o
);
  import erc_pkg::*;

  localparam int REFRESH_CYC = `ERC_REFRESH_CYC;
  localparam int EXTEND_CYC = `ERC_EXTEND_CYC;

  // ---------------------------------------------------------------
  // reset release and pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_sync_q <= 2'b00;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // bus strobes and protect arrive from outside the clock domain
  logic [4:0] pin_meta_q;
  logic [4:0] pin_q;
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta_q <= 5'h00;
      pin_q <= 5'h00;
    end
    else
    begin
      pin_meta_q <= {~mem_protect_n_i, mem_rd_i, mem_wr_i, io_rd_i, io_wr_i};
      pin_q <= pin_meta_q;
    end
  end
  logic protect, mrd, mwr, iord, iowr;
  assign {protect, mrd, mwr, iord, iowr} = pin_q;

  // ---------------------------------------------------------------
  // address decoding
  // ---------------------------------------------------------------
  // nine fixed port addresses; codes above eight use the spare entry
  function automatic logic [7:0] erc_port_addr(input logic [3:0] sel, input logic [7:0] spare);
    return (sel < `ERC_PORT_SEL_COUNT) ? (8'h80 + {sel, 4'h0}) : spare;
  endfunction : erc_port_addr
  logic mem_hit, io_hit;
  logic [7:0] blk_off;
  always_comb
  begin
    blk_off = mem_addr_i[21:14] - base_block_i;
    // the board never spans past the end of its page
    mem_hit = (mem_addr_i[23:22] == page_sel_i) && (mem_addr_i[21:14] >= base_block_i)
              && (blk_off < {2'b00, `ERC_BLOCKS_ON_BOARD});
    io_hit = (io_addr_i == erc_port_addr(port_sel_i, spare_port_i));
  end

  // ---------------------------------------------------------------
  // mode control register and io port
  // ---------------------------------------------------------------
  logic [7:0] mode_q, log_q;
  logic io_busy_q;
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_q <= `ERC_MODE_RESET;
    end
    else if (iowr && io_hit && !io_busy_q)
    begin
      mode_q <= io_wdata_i;
    end
  end

  // a held strobe is answered every other cycle; reads return the log
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_busy_q <= 1'b0;
      io_rdata_o <= 8'h00;
    end
    else
    begin
      io_busy_q <= (iord || iowr) && io_hit && !io_busy_q;
      if (iord && io_hit && !io_busy_q)
      begin
        io_rdata_o <= log_q;
      end
    end
  end
  assign io_ack_o = io_busy_q;

  logic int_any, int_unc, correct_en, diag_en, synd_en;
  assign int_any = mode_q[`ERC_MODE_INT_ANY_BIT];
  assign int_unc = mode_q[`ERC_MODE_INT_UNC_BIT];
  assign correct_en = mode_q[`ERC_MODE_CORRECT_BIT];
  assign diag_en = mode_q[`ERC_MODE_DIAG_BIT];
  assign synd_en = mode_q[`ERC_MODE_SYND_BIT];

  // ---------------------------------------------------------------
  // check code
  // ---------------------------------------------------------------
  logic [5:0] gen_chk, syndrome;
  logic err_single, err_multi;
  logic [4:0] err_code;
  logic [15:0] fixed, code_data, wr_merge;
  erc_state_t state_q;
  logic is_write_q;

  // byte writes merge the new byte into the stored word before encoding
  always_comb
  begin
    wr_merge = byte_en_n_i ? mem_wdata_i : (mem_addr_i[0] ? {mem_wdata_i[15:8], ram_rdata_i[7:0]}
               : {ram_rdata_i[15:8], mem_wdata_i[7:0]});
    // writes pass the read state too; they must encode the new word, not the old one
    code_data = ((state_q == ERC_READ) && !is_write_q) ? ram_rdata_i : wr_merge;
  end

  erc_secded u_secded (
    .data_i(code_data),
    .check_i(check_rdata_i),
    .gen_o(gen_chk),
    .syndrome_o(syndrome),
    .single_o(err_single),
    .multi_o(err_multi),
    .code_o(err_code),
    .fixed_o(fixed)
  );

  // ---------------------------------------------------------------
  // access and refresh sequencer
  // ---------------------------------------------------------------
  logic [11:0] ref_cnt_q;
  logic [5:0] ext_cnt_q;
  logic ref_pend_q, err_hit, take;

  assign err_hit = err_single || err_multi;
  // protect blocks every memory access; the cycle is left unanswered
  assign take = (mrd || mwr) && mem_hit && !protect && !mem_ack_o;

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_cnt_q <= 12'h000;
      ref_pend_q <= 1'b0;
    end
    else
    begin
      if (ref_cnt_q == 12'(REFRESH_CYC - 1))
      begin
        ref_cnt_q <= 12'h000;
        ref_pend_q <= 1'b1;
      end
      else
      begin
        ref_cnt_q <= ref_cnt_q + 12'h001;
        if (state_q == ERC_REFRESH)
        begin
          ref_pend_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ERC_IDLE;
      is_write_q <= 1'b0;
      ext_cnt_q <= 6'h00;
    end
    else
    begin
      case (state_q)
        ERC_IDLE:
        begin
          if (ref_pend_q)
          begin
            state_q <= ERC_REFRESH;
          end
          else if (take)
          begin
            is_write_q <= mwr;
            state_q <= ERC_READ;
          end
        end
        ERC_READ:
        begin
          ext_cnt_q <= 6'(EXTEND_CYC);
          // a read with an error waits for the corrected word
          state_q <= (err_hit && !is_write_q) ? ERC_EXTEND : ERC_ACK;
        end
        ERC_EXTEND:
        begin
          ext_cnt_q <= ext_cnt_q - 6'h01;
          if (ext_cnt_q == 6'h01)
          begin
            state_q <= ERC_ACK;
          end
        end
        ERC_ACK:
        begin
          if (!mrd && !mwr)
          begin
            state_q <= ERC_IDLE;
          end
        end
        // a refresh lasts one cycle; it and any stray code return to idle
        default:
        begin
          state_q <= ERC_IDLE;
        end
      endcase
    end
  end

  assign mem_ack_o = (state_q == ERC_ACK);
  assign refresh_o = (state_q == ERC_REFRESH);
  assign ram_addr_o = {blk_off[4:0], mem_addr_i[13:0]};
  assign ram_rd_o = (state_q == ERC_READ);

  // ---------------------------------------------------------------
  // write path, read data and error log
  // ---------------------------------------------------------------
  logic wr_cycle;
  assign wr_cycle = (state_q == ERC_READ) && is_write_q;

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ram_wr_o <= 2'b00;
      check_wr_o <= 1'b0;
      ram_wdata_o <= 16'h0000;
      check_wdata_o <= 6'h00;
      mem_rdata_o <= 16'h0000;
    end
    else
    begin
      ram_wr_o <= {2{wr_cycle}};
      ram_wdata_o <= wr_merge;
      check_wdata_o <= gen_chk;
      check_wr_o <= wr_cycle && !diag_en;
      if ((state_q == ERC_READ) && !is_write_q)
      begin
        // uncorrectable words and non-correcting mode pass through as read
        mem_rdata_o <= (correct_en && err_single) ? fixed : ram_rdata_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      log_q <= `ERC_LOG_RESET;
    end
    else if (state_q == ERC_READ)
    begin
      if (synd_en)
      begin
        // raw word: syndrome on reads, generated check bits on writes
        log_q <= {1'b1, 1'b0, is_write_q ? gen_chk : syndrome};
      end
      else if (err_hit && !is_write_q)
      begin
        log_q <= {1'b1, blk_off[4:3], err_code};
      end
    end
  end

  // interrupt stands until the mode register is rewritten
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_o <= 1'b0;
    end
    else if ((state_q == ERC_READ) && !is_write_q
             && ((int_any && err_hit) || (int_unc && err_multi)))
    begin
      int_o <= 1'b1;
    end
    else if (iowr && io_hit && !io_busy_q)
    begin
      int_o <= 1'b0;
    end
  end
endmodule : erc_ctrl

/* core/erc_map.svh */
// field positions, reset values and timing counts of the ecc board control
`ifndef ERC_MAP_SVH
`define ERC_MAP_SVH
// clock
`define ERC_CLK_PS 8000
// refresh interval in ns and its cycle count (longest time, rounded down)
`define ERC_REFRESH_NS 15600
`define ERC_REFRESH_CYC ((`ERC_REFRESH_NS * 1000) / `ERC_CLK_PS)
// read extension on a detected error in ns, least time, rounded up
`define ERC_EXTEND_NS 255
`define ERC_EXTEND_CYC (((`ERC_EXTEND_NS * 1000) + `ERC_CLK_PS - 1) / `ERC_CLK_PS)
// mode control register fields
`define ERC_MODE_INT_ANY_BIT 0
`define ERC_MODE_INT_UNC_BIT 1
`define ERC_MODE_CORRECT_BIT 2
`define ERC_MODE_DIAG_BIT 3
`define ERC_MODE_SYND_BIT 4
`define ERC_MODE_RESET 8'h04
// error log fields
`define ERC_LOG_ONE_BIT 7
`define ERC_LOG_ROW_HI 6
`define ERC_LOG_ROW_LO 5
`define ERC_LOG_CODE_HI 4
`define ERC_LOG_RESET 8'h96
// 5-bit error codes: data bits 0..15 as 0x00..0x0F, check bits 0..5 as 0x10..0x15
`define ERC_CODE_CHECK0 5'h10
`define ERC_CODE_NONE 5'h16
`define ERC_CODE_MULTI 5'h17
// address geometry
`define ERC_BLOCKS_ON_BOARD 6'h20
`define ERC_PORT_SEL_COUNT 4'h9
`endif

/* core/erc_pkg.sv */
// types of the ecc board control
package erc_pkg;
  typedef enum logic [4:0] {
    ERC_IDLE = 5'h01,
    ERC_READ = 5'h02,
    ERC_EXTEND = 5'h04,
    ERC_ACK = 5'h08,
    ERC_REFRESH = 5'h10
  } erc_state_t;
endpackage : erc_pkg

/* core/erc_secded.sv */
// single-error-correct double-error-detect code over 16 data bits and 6 check bits
`timescale 1ns/1ps
`include "erc_map.svh"
module erc_secded (
  // data and stored check bits
  input wire logic [15:0] data_i,
  input wire logic [5:0] check_i,
  // results
  output logic [5:0] gen_o,
  output logic [5:0] syndrome_o,
  output logic single_o,
  output logic multi_o,
  output logic [4:0] code_o,
  output logic [15:0] fixed_o
);
  // ---------------------------------------------------------------
  // hamming positions 1..21 for the 16 data bits, overall parity bit 5
  // ---------------------------------------------------------------
  function automatic logic [4:0] erc_pos(input int i);
    logic [4:0] p;
    int n;
    n = 0;
    p = 5'h00;
    for (int k = 1; k < 22; k++)
    begin
      if ((k & (k - 1)) != 0)
      begin
        if (n == i)
        begin
          p = k[4:0];
        end
        n = n + 1;
      end
    end
    return p;
  endfunction : erc_pos

  function automatic logic [5:0] erc_gen(input logic [15:0] d);
    logic [5:0] c;
    logic [4:0] p;
    c = 6'h00;
    for (int i = 0; i < 16; i++)
    begin
      p = erc_pos(i);
      for (int b = 0; b < 5; b++)
      begin
        c[b] = c[b] ^ (d[i] & p[b]);
      end
    end
    c[5] = ^d ^ (^c[4:0]);
    return c;
  endfunction : erc_gen

  logic [5:0] cmp;
  logic overall;

  always_comb
  begin
    gen_o = erc_gen(data_i);
    cmp = erc_gen(data_i);
    syndrome_o = cmp ^ check_i;
    overall = (^data_i) ^ (^check_i);
    single_o = overall;
    multi_o = !overall && (syndrome_o[4:0] != 5'h00);
    code_o = `ERC_CODE_NONE;
    fixed_o = data_i;
    if (multi_o)
    begin
      code_o = `ERC_CODE_MULTI;
    end
    else if (single_o)
    begin
      code_o = `ERC_CODE_CHECK0 + 5'h05;
      for (int b = 0; b < 5; b++)
      begin
        if (syndrome_o[4:0] == (5'h01 << b))
        begin
          code_o = `ERC_CODE_CHECK0 + 5'(b);
        end
      end
      for (int i = 0; i < 16; i++)
      begin
        if (syndrome_o[4:0] == erc_pos(i))
        begin
          code_o = 5'(i);
          fixed_o[i] = ~data_i[i];
        end
      end
    end
  end
endmodule : erc_secded

/* test/ecc_ram_board_control_test.sv */
// self-checking bench of the ecc board control
`timescale 1ns/1ps
`include "erc_map.svh"
`define CHK(a, e) \
  begin checks++; if ((a) !== (e)) begin fails++; \
  $display("BAD %0t got %0h want %0h", $time, a, e); end end
module ecc_ram_board_control_test;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [1:0] page_sel_i = 2'h0;
  logic [7:0] base_block_i = 8'h00;
  logic [3:0] port_sel_i = 4'h3;
  logic [7:0] spare_port_i = 8'h00;
  logic [23:0] mem_addr_i = 24'h000000;
  logic mem_rd_i = 1'b0;
  logic mem_wr_i = 1'b0;
  logic byte_en_n_i = 1'b1;
  logic [15:0] mem_wdata_i = 16'h0000;
  logic [15:0] mem_rdata_o;
  logic mem_ack_o;
  logic [7:0] io_addr_i = 8'h00;
  logic io_rd_i = 1'b0;
  logic io_wr_i = 1'b0;
  logic [7:0] io_wdata_i = 8'h00;
  logic [7:0] io_rdata_o;
  logic io_ack_o;
  logic int_o;
  logic mem_protect_n_i = 1'b1;
  logic [18:0] ram_addr_o;
  logic ram_rd_o;
  logic [1:0] ram_wr_o;
  logic [15:0] ram_wdata_o;
  logic [15:0] ram_rdata_i;
  logic check_wr_o;
  logic [5:0] check_wdata_o;
  logic [5:0] check_rdata_i;
  logic refresh_o;
  logic [21:0] flip = 22'h000000;
  int chk_cnt;
  int fails = 0;
  int checks = 0;
  int seed = 58065;
  int cyc = 0;
  int lat;
  int lat0;
  int i;
  int m;
  logic ack;
  logic [15:0] rd;
  logic [15:0] d;
  logic [7:0] log_v;
  logic [7:0] port = 8'hB0;
  logic [7:0] modes [4] = '{8'h05, 8'h06, 8'h01, 8'h02};
  erc_ctrl u_dut (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .page_sel_i(page_sel_i),
    .base_block_i(base_block_i),
    .port_sel_i(port_sel_i),
    .spare_port_i(spare_port_i),
    .mem_addr_i(mem_addr_i),
    .mem_rd_i(mem_rd_i),
    .mem_wr_i(mem_wr_i),
    .byte_en_n_i(byte_en_n_i),
    .mem_wdata_i(mem_wdata_i),
    .mem_rdata_o(mem_rdata_o),
    .mem_ack_o(mem_ack_o),
    .io_addr_i(io_addr_i),
    .io_rd_i(io_rd_i),
    .io_wr_i(io_wr_i),
    .io_wdata_i(io_wdata_i),
    .io_rdata_o(io_rdata_o),
    .io_ack_o(io_ack_o),
    .int_o(int_o),
    .mem_protect_n_i(mem_protect_n_i),
    .ram_addr_o(ram_addr_o),
    .ram_rd_o(ram_rd_o),
    .ram_wr_o(ram_wr_o),
    .ram_wdata_o(ram_wdata_o),
    .ram_rdata_i(ram_rdata_i),
    .check_wr_o(check_wr_o),
    .check_wdata_o(check_wdata_o),
    .check_rdata_i(check_rdata_i),
    .refresh_o(refresh_o)
  );
  erc_ram_model u_ram (
    .clk_i(ref_clk_i),
    .addr_i(ram_addr_o),
    .rd_i(ram_rd_o),
    .wr_i(ram_wr_o),
    .wdata_i(ram_wdata_o),
    .chk_wr_i(check_wr_o),
    .chk_wdata_i(check_wdata_o),
    .flip_i(flip),
    .rdata_o(ram_rdata_i),
    .chk_rdata_o(check_rdata_i),
    .chk_cnt_o(chk_cnt)
  );
  initial forever #4 ref_clk_i = ~ref_clk_i;
  function automatic logic [23:0] at(input int off, input logic [13:0] lo);
    return {page_sel_i, base_block_i + 8'(off), lo};
  endfunction : at
  function automatic logic [7:0] exp_log(input int off, input logic [4:0] code);
    return {1'b1, 2'(off >> 3), code};
  endfunction : exp_log
  function automatic logic [15:0] exp_rd(input logic [7:0] mo, input logic [15:0] dv, input int dbl);
    return (mo[2] && dbl == 0) ? dv : dv ^ ((dbl != 0) ? 16'h0006 : 16'h0020);
  endfunction : exp_rd
  task end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  task automatic wait_ack(ref logic s, input int lim);
    lat = 0;
    ack = 1'b0;
    while (!ack && lat < lim)
    begin
      @(posedge ref_clk_i);
      lat++;
      ack = (s === 1'b1);
    end
  endtask : wait_ack
  task automatic mem_op(input logic w, input logic [23:0] a, input logic [15:0] dv, input logic bw);
    @(posedge ref_clk_i);
    mem_addr_i <= a;
    mem_wdata_i <= dv;
    byte_en_n_i <= ~bw;
    mem_wr_i <= w;
    mem_rd_i <= ~w;
    wait_ack(mem_ack_o, 90);
    rd = mem_rdata_o;
    mem_wr_i <= 1'b0;
    mem_rd_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
  endtask : mem_op
  task automatic io_op(input logic w, input logic [7:0] a, input logic [7:0] dv);
    @(posedge ref_clk_i);
    io_addr_i <= a;
    io_wdata_i <= dv;
    io_wr_i <= w;
    io_rd_i <= ~w;
    wait_ack(io_ack_o, 12);
    log_v = io_rdata_o;
    io_wr_i <= 1'b0;
    io_rd_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
  endtask : io_op
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      end_sim();
    end
  end
  initial
  begin
    page_sel_i <= 2'($random(seed));
    base_block_i <= 8'($random(seed)) & 8'h7F;
    repeat (10) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    io_op(1'b0, port, 8'h00);
    `CHK(log_v, 8'h96)
    $display("reset test done");
    // every data and check bit in turn, on random rows
    for (i = 0; i < 22; i++)
    begin
      m = $random(seed) & 31;
      d = 16'($random(seed));
      mem_op(1'b1, at(m, 14'(i * 2)), d, 1'b0);
      flip <= 22'h1 << i;
      mem_op(1'b0, at(m, 14'(i * 2)), 16'h0000, 1'b0);
      flip <= 22'h000000;
      `CHK(rd, d)
      io_op(1'b0, port, 8'h00);
      `CHK(log_v, exp_log(m, 5'(i)))
      `CHK(int_o, 1'b0)
    end
    $display("single error test done");
    for (i = 0; i < 8; i++)
    begin
      io_op(1'b1, port, modes[i / 2]);
      d = 16'($random(seed));
      mem_op(1'b1, at(7, 14'h0040), d, 1'b0);
      flip <= (i % 2 != 0) ? 22'h000006 : 22'h000020;
      mem_op(1'b0, at(7, 14'h0040), 16'h0000, 1'b0);
      flip <= 22'h000000;
      `CHK(rd, exp_rd(modes[i / 2], d, i % 2))
      `CHK(int_o, modes[i / 2][0] | (modes[i / 2][1] & i[0]))
      io_op(1'b0, port, 8'h00);
      `CHK(log_v, exp_log(7, (i % 2 != 0) ? 5'h17 : 5'h05))
    end
    $display("mode test done");
    io_op(1'b1, port, 8'h04);
    mem_op(1'b1, at(3, 14'h0010), 16'hA5C3, 1'b0);
    for (m = 0; m < 2100 && refresh_o !== 1'b1; m++)
      @(posedge ref_clk_i);
    `CHK(refresh_o, 1'b1)
    repeat (20) @(posedge ref_clk_i);
    mem_op(1'b0, at(3, 14'h0010), 16'h0000, 1'b0);
    lat0 = lat;
    flip <= 22'h000001;
    mem_op(1'b0, at(3, 14'h0010), 16'h0000, 1'b0);
    flip <= 22'h000000;
    `CHK(lat - lat0, `ERC_EXTEND_CYC)
    $display("timing test done");
    // byte value on both lanes, so lane choice is left to the design
    mem_op(1'b1, at(2, 14'h0200), 16'h1234, 1'b0);
    mem_op(1'b1, at(2, 14'h0201), 16'h9999, 1'b1);
    mem_op(1'b1, at(2, 14'h0200), 16'h6666, 1'b1);
    mem_op(1'b0, at(2, 14'h0200), 16'h0000, 1'b0);
    `CHK(rd, 16'h9966)
    io_op(1'b1, port, 8'h0C);
    lat0 = chk_cnt;
    mem_op(1'b1, at(4, 14'h0300), 16'h00FF, 1'b0);
    `CHK(chk_cnt, lat0)
    io_op(1'b1, port, 8'h14);
    mem_op(1'b1, at(5, 14'h0100), 16'($random(seed)), 1'b0);
    mem_op(1'b0, at(5, 14'h0100), 16'h0000, 1'b0);
    io_op(1'b0, port, 8'h00);
    `CHK(log_v, 8'h80)
    flip <= 22'h010000;
    mem_op(1'b0, at(5, 14'h0100), 16'h0000, 1'b0);
    flip <= 22'h000000;
    io_op(1'b0, port, 8'h00);
    `CHK(log_v, 8'h81)
    $display("diagnostic test done");
    io_op(1'b1, port, 8'h04);
    mem_op(1'b1, at(1, 14'h0080), 16'h5A5A, 1'b0);
    mem_protect_n_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    mem_op(1'b1, at(1, 14'h0080), 16'h0F0F, 1'b0);
    `CHK(ack, 1'b0)
    mem_protect_n_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    mem_op(1'b0, at(1, 14'h0080), 16'h0000, 1'b0);
    `CHK(rd, 16'h5A5A)
    mem_op(1'b0, at(32, 14'h0000), 16'h0000, 1'b0);
    `CHK(ack, 1'b0)
    mem_op(1'b0, at(1, 14'h0080) ^ 24'h400000, 16'h0000, 1'b0);
    `CHK(ack, 1'b0)
    io_op(1'b0, port ^ 8'h10, 8'h00);
    `CHK(ack, 1'b0)
    port = 8'($random(seed)) | 8'h01;
    spare_port_i <= port;
    port_sel_i <= 4'hC;
    io_op(1'b0, port, 8'h00);
    `CHK(ack, 1'b1)
    $display("access test done");
    end_sim();
  end
endmodule : ecc_ram_board_control_test

/* test/erc_ctrl_checker.sv */
// port checker of the ecc board control
`timescale 1ns/1ps
`include "erc_map.svh"
module erc_ctrl_checker (
  // clock, reset and straps
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [3:0] port_sel_i,
  input wire logic [7:0] spare_port_i,
  // buses
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire logic mem_ack_o,
  input wire logic [7:0] io_addr_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic io_ack_o,
  input wire logic int_o,
  // array side
  input wire logic mem_protect_n_i,
  input wire logic ram_rd_o,
  input wire logic [1:0] ram_wr_o,
  input wire logic check_wr_o,
  input wire logic refresh_o
);
  // slack covers a refresh held back behind one extended access
  localparam int GAP_MAX = `ERC_REFRESH_CYC + 64;
  logic [11:0] gap_q;
  logic [7:0] port_w;
  assign port_w = (port_sel_i < 4'h9) ? {port_sel_i + 4'h8, 4'h0} : spare_port_i;
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      gap_q <= 12'h000;
    else if (refresh_o)
      gap_q <= 12'h000;
    else
      gap_q <= gap_q + 12'h001;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // ----
  // properties
  // ----
  ack_release_a: assert property (!(mem_rd_i || mem_wr_i) [*4] |-> !mem_ack_o)
    else $error("ack held without strobe");
  ack_cause_a: assert property ($rose(mem_ack_o) |-> $past(mem_rd_i, 3) || $past(mem_wr_i, 3))
    else $error("ack without request");
  protect_block_a: assert property (!mem_protect_n_i [*5] |->
    ram_wr_o == 2'b00 && !ram_rd_o && !check_wr_o)
    else $error("array touched while protected");
  io_ack_a: assert property (io_ack_o |-> ($past(io_rd_i, 3) || $past(io_wr_i, 3))
    && !$past(io_ack_o))
    else $error("io ack without strobe");
  io_port_a: assert property (io_ack_o |-> $past(io_addr_i, 3) == port_w)
    else $error("io ack on wrong port");
  int_clear_a: assert property (io_ack_o && $past(io_wr_i, 3) |-> ##[0:1] !int_o)
    else $error("mode write left interrupt up");
  refresh_gap_a: assert property (int'(gap_q) <= GAP_MAX)
    else $error("refresh overdue");
  wr_cause_a: assert property ((ram_wr_o != 2'b00 || check_wr_o) |->
    $past(mem_wr_i, 4) && mem_wr_i)
    else $error("array write without bus write");
  int_hit_c: cover property ($rose(int_o));
  refresh_c: cover property (refresh_o);
  io_read_c: cover property (io_ack_o && $past(io_rd_i, 3));
endmodule : erc_ctrl_checker

bind erc_ctrl erc_ctrl_checker u_chk (
  .ref_clk_i(ref_clk_i),
  .nrst_i(nrst_i),
  .port_sel_i(port_sel_i),
  .spare_port_i(spare_port_i),
  .mem_rd_i(mem_rd_i),
  .mem_wr_i(mem_wr_i),
  .mem_ack_o(mem_ack_o),
  .io_addr_i(io_addr_i),
  .io_rd_i(io_rd_i),
  .io_wr_i(io_wr_i),
  .io_ack_o(io_ack_o),
  .int_o(int_o),
  .mem_protect_n_i(mem_protect_n_i),
  .ram_rd_o(ram_rd_o),
  .ram_wr_o(ram_wr_o),
  .check_wr_o(check_wr_o),
  .refresh_o(refresh_o)
);

/* test/erc_ram_model.sv */
// behavioural data and check-bit arrays behind the board
`timescale 1ns/1ps
module erc_ram_model (
  // array control
  input wire logic clk_i,
  input wire logic [18:0] addr_i,
  input wire logic rd_i,
  input wire logic [1:0] wr_i,
  input wire logic [15:0] wdata_i,
  input wire logic chk_wr_i,
  input wire logic [5:0] chk_wdata_i,
  // fault injection and observation
  input wire logic [21:0] flip_i,
  output logic [15:0] rdata_o,
  output logic [5:0] chk_rdata_o,
  output int chk_cnt_o
);
  logic [21:0] mem_q [0:1023] = '{default: 22'h000000};
  logic [21:0] word_w;
  int cnt_q = 0;
  assign chk_cnt_o = cnt_q;
  // check bits live in their own lanes; an idle array shows the inverse, never stale data
  assign word_w = mem_q[addr_i[10:1]] ^ flip_i;
  assign rdata_o = rd_i ? word_w[15:0] : ~word_w[15:0];
  assign chk_rdata_o = rd_i ? word_w[21:16] : ~word_w[21:16];
  always @(posedge clk_i)
  begin
    if (wr_i[0])
      mem_q[addr_i[10:1]][7:0] <= wdata_i[7:0];
    if (wr_i[1])
      mem_q[addr_i[10:1]][15:8] <= wdata_i[15:8];
    if (chk_wr_i)
      mem_q[addr_i[10:1]][21:16] <= chk_wdata_i;
    if (chk_wr_i)
      cnt_q <= cnt_q + 1;
  end
endmodule : erc_ram_model
